//--- core/ptb_pkg.sv
// Shared constants and types of the PHY test and bring-up block.
// Assumes one 25 MHz system clock and a 16-bit management register space.
package ptb_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned SRST_NS = 1000;
  localparam int unsigned SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GEN_FRAMES_DFLT = 30000000;
  // Register indices, byte address is four times the index
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam logic [4:0] REG_ANADV = 5'h04;
  localparam logic [4:0] REG_GBCTL = 5'h09;
  localparam logic [4:0] REG_MMD_CTL = 5'h0D;
  localparam logic [4:0] REG_MMD_DAT = 5'h0E;
  localparam logic [4:0] REG_BYPASS = 5'h12;
  localparam logic [4:0] REG_EXTCTL1 = 5'h17;
  localparam logic [4:0] REG_EXTCTL2 = 5'h18;
  localparam logic [4:0] REG_IRQ_STAT = 5'h1A;
  localparam logic [4:0] REG_PAGE = 5'h1F;
  localparam logic [4:0] REG_EXT_FIRST = 5'h10;
  localparam logic [4:0] REG_EXT1_FIRST = 5'h11;
  localparam logic [4:0] REG_GEN_CTL = 5'h1D;
  localparam logic [4:0] REG_GEN_CFG = 5'h1E;
  localparam logic [4:0] REG_RGMII = 5'h14;
  // Page codes
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;
  localparam logic [15:0] PAGE_GPIO = 16'h0010;
  // Bit positions
  localparam int unsigned CTRL_SRST = 15;
  localparam int unsigned CTRL_NEAR_LB = 14;
  localparam int unsigned CTRL_SPD_LSB = 13;
  localparam int unsigned CTRL_AN_EN = 12;
  localparam int unsigned CTRL_ISOLATE = 10;
  localparam int unsigned CTRL_DUPLEX = 8;
  localparam int unsigned CTRL_SPD_MSB = 6;
  localparam int unsigned STAT_LINK = 2;
  localparam int unsigned STAT_RXER = 1;
  localparam int unsigned EXT1_MODE_HI = 12;
  localparam int unsigned EXT1_MODE_LO = 11;
  localparam int unsigned EXT1_FAR_LB = 3;
  localparam int unsigned EXT2_CONN_LB = 0;
  localparam int unsigned BYP_PAIRSWAP = 5;
  localparam int unsigned RGM_DLY_OFF = 11;
  localparam int unsigned GEN_ENA = 15;
  localparam int unsigned GEN_RUN = 14;
  localparam int unsigned GEN_CONT = 13;
  localparam int unsigned GEN_LEN_LSB = 4;
  localparam int unsigned GEN_GAP_LSB = 0;
  localparam int unsigned IRQ_GEN_DONE = 0;
  localparam int unsigned MMD_FUNC_LSB = 14;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h1040;
  localparam logic [15:0] STAT_RST = 16'h7000;
  localparam logic [15:0] ANADV_RST = 16'h01E1;
  localparam logic [15:0] RGMII_RST = 16'h0000;
  // Generator frame layout
  localparam logic [3:0] GEN_ADDR_BYTES = 4'h6;
  localparam logic [7:0] GEN_SA_BYTE = 8'h02;

  typedef enum logic [2:0] {SP_MAIN, SP_EXT1, SP_EXT2, SP_GPIO, SP_NONE} ptb_space_e;
  typedef enum logic [2:0] {GEN_IDLE, GEN_DA, GEN_SA, GEN_PAY, GEN_GAP} ptb_gen_e;

  typedef struct packed {
    logic en;
    logic [7:0] d;
  } ptb_byte_s;

  typedef struct packed {
    logic [31:0][15:0] main;
    logic [31:0][15:0] ext1;
    logic [31:0][15:0] ext2;
    logic [31:0][15:0] gpio;
    logic [7:0][15:0] mmd;
    logic [15:0] mmd_addr;
    logic ack;
    logic [15:0] rdata;
    logic srst_busy;
    logic [7:0] srst_cnt;
    logic link_lat;
    logic rxer_lat;
    ptb_gen_e gen_st;
    logic [7:0] gen_cnt;
    logic [24:0] frame_cnt;
    ptb_byte_s mac_rx;
    ptb_byte_s med_tx;
  } ptb_state_s;
endpackage

//--- core/ptb_top.sv
// PHY test and bring-up core: register space, loopbacks, packet generator.
// Assumes an Avalon-MM master on SYS_CLK and byte-wide data paths on both sides.
// What this block does
// - Generator enable replaces MAC transmit path
// - MAC receive stays live unless isolated
// - Run bit starts configured generator frames
// - Non-continuous run stops after frame limit
// - Far-end loopback echoes media and MAC
// - Far-end loopback ignores MAC transmit data
// - Near-end loopback returns MAC data, media silent unless the generator is enabled
// - Connector loopback uses registers 0,4,9 settings
// - MAC interface mode from register 23
// - Sleep pin high keeps PHY inactive
// - Register bits honour their access types
// - Standard, extended and general pages exist
// - Indirect MMD access through registers 13, 14
// - Registers are sixteen bits, MSB first
// - Main registers 16-30 need page zero
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/10ps
module ptb_top #(
  parameter int unsigned GEN_FRAMES = ptb_pkg::GEN_FRAMES_DFLT,
  parameter logic [15:0] PHY_ID1 = 16'h1234,
  parameter logic [15:0] PHY_ID2 = 16'h5670
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [6:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic SLEEP_HOLD_PIN,
  input wire ptb_pkg::ptb_byte_s MAC_TX,
  output ptb_pkg::ptb_byte_s MAC_RX,
  input wire ptb_pkg::ptb_byte_s MED_RX,
  input wire logic MED_RX_ER,
  input wire logic MED_LINK,
  output ptb_pkg::ptb_byte_s MED_TX,
  output logic [1:0] MAC_MODE,
  output logic AN_ENABLE,
  output logic [1:0] FORCED_SPEED,
  output logic FULL_DUPLEX,
  output logic [15:0] AN_ADVERT,
  output logic [15:0] GB_CONTROL,
  output logic CONN_LOOPBACK,
  output logic PAIR_SWAP_OFF,
  output logic RGMII_DLY_ON,
  output logic [2:0] RGMII_RX_DLY,
  output logic [2:0] RGMII_TX_DLY,
  output logic PHY_ACTIVE
);
  import ptb_pkg::*;

  ptb_state_s s;
  ptb_state_s n;

  logic req;
  logic [4:0] idx;
  ptb_space_e sp;
  logic [15:0] rv;
  logic [15:0] cur;
  logic [15:0] mask;
  logic [15:0] wv;
  logic active;
  logic gen_on;
  logic far_lb;
  logic near_lb;
  logic isolate;
  ptb_byte_s gen_b;
  logic [7:0] pay_len;
  logic [7:0] gap_len;
  logic frame_end;

  assign req = READ | WRITE;
  assign WAITREQUEST = req & ~s.ack;
  assign READDATA = {16'h0000, s.rdata};
  assign MAC_RX = s.mac_rx;
  assign MED_TX = s.med_tx;
  assign MAC_MODE = s.main[REG_EXTCTL1][EXT1_MODE_HI:EXT1_MODE_LO];
  assign AN_ENABLE = s.main[REG_CTRL][CTRL_AN_EN];
  assign FORCED_SPEED = {s.main[REG_CTRL][CTRL_SPD_MSB], s.main[REG_CTRL][CTRL_SPD_LSB]};
  assign FULL_DUPLEX = s.main[REG_CTRL][CTRL_DUPLEX];
  assign AN_ADVERT = s.main[REG_ANADV];
  assign GB_CONTROL = s.main[REG_GBCTL];
  assign CONN_LOOPBACK = s.main[REG_EXTCTL2][EXT2_CONN_LB];
  assign PAIR_SWAP_OFF = s.main[REG_BYPASS][BYP_PAIRSWAP];
  assign RGMII_DLY_ON = ~s.ext2[REG_RGMII][RGM_DLY_OFF];
  assign RGMII_RX_DLY = s.ext2[REG_RGMII][6:4];
  assign RGMII_TX_DLY = s.ext2[REG_RGMII][2:0];
  assign PHY_ACTIVE = active;

  // Sleep pin or an internal reset keep the data paths quiet
  assign active = ~SLEEP_HOLD_PIN & ~s.srst_busy;
  assign gen_on = s.ext1[REG_GEN_CTL][GEN_ENA];
  assign far_lb = s.main[REG_EXTCTL1][EXT1_FAR_LB];
  assign near_lb = s.main[REG_CTRL][CTRL_NEAR_LB];
  assign isolate = s.main[REG_CTRL][CTRL_ISOLATE];
  assign pay_len = s.ext1[REG_GEN_CTL][GEN_LEN_LSB +: 8];
  assign gap_len = {4'h0, s.ext1[REG_GEN_CTL][GEN_GAP_LSB +: 4]};
  assign frame_end = (s.gen_st == GEN_GAP) && (s.gen_cnt == gap_len);

  // Address decode through the page register
  always_comb begin
    idx = ADDRESS[6:2];
    if (idx == REG_PAGE) begin
      sp = SP_MAIN;
    end else if (s.main[REG_PAGE] == PAGE_GPIO) begin
      sp = SP_GPIO;
    end else if (idx < REG_EXT_FIRST) begin
      sp = SP_MAIN;
    end else if (s.main[REG_PAGE] == PAGE_MAIN) begin
      sp = SP_MAIN;
    end else if (s.main[REG_PAGE] == PAGE_EXT1 && idx >= REG_EXT1_FIRST) begin
      sp = SP_EXT1;
    end else if (s.main[REG_PAGE] == PAGE_EXT2) begin
      sp = SP_EXT2;
    end else begin
      sp = SP_NONE;
    end
  end

  // Generator byte from its state
  always_comb begin
    gen_b = '0;
    case (s.gen_st)
      GEN_DA: begin
        gen_b.en = 1'b1;
        gen_b.d = s.ext1[REG_GEN_CFG][15:8];
      end
      GEN_SA: begin
        gen_b.en = 1'b1;
        gen_b.d = GEN_SA_BYTE;
      end
      GEN_PAY: begin
        gen_b.en = 1'b1;
        gen_b.d = s.ext1[REG_GEN_CFG][7:0];
      end
      default: begin
        gen_b = '0;
      end
    endcase
  end

  always_comb begin
    n = s;
    cur = 16'h0000;
    rv = 16'h0000;
    mask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
    // Read value, with access-type views
    case (sp)
      SP_MAIN: begin
        cur = s.main[idx];
        if (idx == REG_CTRL) begin
          rv = {s.srst_busy, s.main[REG_CTRL][14:0]};
        end else if (idx == REG_STAT) begin
          rv = STAT_RST;
          rv[STAT_LINK] = s.link_lat;
          rv[STAT_RXER] = s.rxer_lat;
        end else if (idx == REG_ID1) begin
          rv = PHY_ID1;
        end else if (idx == REG_ID2) begin
          rv = PHY_ID2;
        end else if (idx == REG_MMD_DAT) begin
          if (s.main[REG_MMD_CTL][MMD_FUNC_LSB +: 2] == 2'b00) begin
            rv = s.mmd_addr;
          end else begin
            rv = s.mmd[s.mmd_addr[2:0]];
          end
        end else begin
          rv = s.main[idx];
        end
      end
      SP_EXT1: begin
        cur = s.ext1[idx];
        rv = cur;
      end
      SP_EXT2: begin
        cur = s.ext2[idx];
        rv = cur;
      end
      SP_GPIO: begin
        cur = s.gpio[idx];
        rv = cur;
      end
      default: begin
        cur = 16'h0000;
        rv = 16'h0000;
      end
    endcase
    wv = (cur & ~mask) | (WRITEDATA[15:0] & mask);

    // One wait state, held off during internal reset
    n.ack = req & ~s.ack & ~s.srst_busy;
    if (req && !s.ack) begin
      n.rdata = rv;
    end

    // Access takes effect at the edge that ends the cycle with WAITREQUEST low
    if (s.ack && READ) begin
      if (sp == SP_MAIN && idx == REG_STAT) begin
        n.link_lat = MED_LINK;
        n.rxer_lat = 1'b0;
      end
      if (sp == SP_MAIN && idx == REG_IRQ_STAT) begin
        n.main[REG_IRQ_STAT] = 16'h0000;
      end
    end
    if (s.ack && WRITE) begin
      case (sp)
        SP_MAIN: begin
          if (idx == REG_CTRL) begin
            n.main[REG_CTRL] = {1'b0, wv[14:0]};
            if (wv[CTRL_SRST]) begin
              n.srst_busy = 1'b1;
              n.srst_cnt = 8'(SRST_CYC - 1);
            end
          end else if (idx == REG_MMD_DAT) begin
            if (s.main[REG_MMD_CTL][MMD_FUNC_LSB +: 2] == 2'b00) begin
              n.mmd_addr = wv;
            end else begin
              n.mmd[s.mmd_addr[2:0]] = wv;
            end
          end else if (idx != REG_STAT && idx != REG_ID1 && idx != REG_ID2 &&
                       idx != REG_IRQ_STAT) begin
            n.main[idx] = wv;
          end
        end
        SP_EXT1: n.ext1[idx] = wv;
        SP_EXT2: n.ext2[idx] = wv;
        SP_GPIO: n.gpio[idx] = wv;
        default: n.rdata = s.rdata;
      endcase
    end

    // Latch-low link and latch-high error, events win over the read
    if (!MED_LINK) begin
      n.link_lat = 1'b0;
    end
    if (MED_RX_ER) begin
      n.rxer_lat = 1'b1;
    end

    // Packet generator
    case (s.gen_st)
      GEN_IDLE: begin
        n.gen_cnt = 8'h00;
        if (gen_on && s.ext1[REG_GEN_CTL][GEN_RUN] && active) begin
          n.gen_st = GEN_DA;
        end
      end
      GEN_DA: begin
        n.gen_cnt = s.gen_cnt + 8'h01;
        if (s.gen_cnt == {4'h0, GEN_ADDR_BYTES} - 8'h01) begin
          n.gen_st = GEN_SA;
          n.gen_cnt = 8'h00;
        end
      end
      GEN_SA: begin
        n.gen_cnt = s.gen_cnt + 8'h01;
        if (s.gen_cnt == {4'h0, GEN_ADDR_BYTES} - 8'h01) begin
          n.gen_st = GEN_PAY;
          n.gen_cnt = 8'h00;
        end
      end
      GEN_PAY: begin
        n.gen_cnt = s.gen_cnt + 8'h01;
        if (s.gen_cnt == pay_len) begin
          n.gen_st = GEN_GAP;
          n.gen_cnt = 8'h00;
        end
      end
      GEN_GAP: begin
        n.gen_cnt = s.gen_cnt + 8'h01;
        if (frame_end) begin
          n.gen_st = GEN_IDLE;
          n.gen_cnt = 8'h00;
          n.frame_cnt = s.frame_cnt + 25'd1;
          if (!s.ext1[REG_GEN_CTL][GEN_CONT] &&
              s.frame_cnt + 25'd1 >= 25'(GEN_FRAMES)) begin
            n.ext1[REG_GEN_CTL][GEN_RUN] = 1'b0;
            n.main[REG_IRQ_STAT][IRQ_GEN_DONE] = 1'b1;
            n.frame_cnt = 25'd0;
          end
        end
      end
      default: n.gen_st = GEN_IDLE;
    endcase
    if (!gen_on) begin
      n.gen_st = GEN_IDLE;
      n.frame_cnt = 25'd0;
    end
    if (s.ext1[REG_GEN_CTL][GEN_RUN] == 1'b0 && gen_on && s.gen_st == GEN_IDLE) begin
      n.frame_cnt = 25'd0;
    end

    // Internal reset countdown and default restore
    if (s.srst_busy) begin
      n.srst_cnt = s.srst_cnt - 8'h01;
      if (s.srst_cnt == 8'h00) begin
        n.srst_busy = 1'b0;
        for (int i = 0; i < 32; i++) begin
          if (i != int'(REG_EXTCTL1)) begin
            n.main[i] = 16'h0000;
          end
          n.ext1[i] = 16'h0000;
        end
        n.main[REG_CTRL] = CTRL_RST;
        n.main[REG_ANADV] = ANADV_RST;
        n.mmd_addr = 16'h0000;
        n.gen_st = GEN_IDLE;
        n.frame_cnt = 25'd0;
      end
    end

    // Media transmit source
    if (!active) begin
      n.med_tx = '0;
    end else if (gen_on) begin
      n.med_tx = gen_b;
    end else if (near_lb) begin
      n.med_tx = '0;
    end else if (far_lb) begin
      n.med_tx = MED_RX;
    end else if (isolate) begin
      n.med_tx = '0;
    end else begin
      n.med_tx = MAC_TX;
    end

    // MAC receive source
    if (!active || isolate) begin
      n.mac_rx = '0;
    end else if (near_lb) begin
      n.mac_rx = MAC_TX;
    end else begin
      n.mac_rx = MED_RX;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.main[REG_CTRL] <= CTRL_RST;
      s.main[REG_ANADV] <= ANADV_RST;
      s.ext2[REG_RGMII] <= RGMII_RST;
      s.gen_st <= GEN_IDLE;
    end else begin
      s <= n;
    end
  end
endmodule

//--- tb/ptb_properties.sv
// Port-level checks of the PHY test and bring-up core.
// Assumes full byte enables and the sleep pin low during bus traffic.
`timescale 1ns/10ps
module ptb_props (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [6:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic WAITREQUEST,
  input wire logic SLEEP_HOLD_PIN,
  input wire ptb_pkg::ptb_byte_s MAC_TX,
  input wire ptb_pkg::ptb_byte_s MAC_RX,
  input wire ptb_pkg::ptb_byte_s MED_RX,
  input wire ptb_pkg::ptb_byte_s MED_TX,
  input wire logic [1:0] MAC_MODE,
  input wire logic [2:0] RGMII_RX_DLY,
  input wire logic [2:0] RGMII_TX_DLY,
  input wire logic PHY_ACTIVE
);
  import ptb_pkg::*;
  logic [15:0] page_r;
  logic near_r;
  logic iso_r;
  logic far_r;
  logic gen_r;
  logic wr_ok;
  logic [4:0] idx;
  assign wr_ok = WRITE && !WAITREQUEST;
  assign idx = ADDRESS[6:2];
  // Shadow of page and test-mode bits
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      page_r <= PAGE_MAIN;
      near_r <= 1'b0;
      iso_r <= 1'b0;
      far_r <= 1'b0;
      gen_r <= 1'b0;
    end else if (wr_ok && page_r == PAGE_MAIN && idx == REG_CTRL && WRITEDATA[CTRL_SRST]) begin
      page_r <= PAGE_MAIN;
      near_r <= 1'b0;
      iso_r <= 1'b0;
      gen_r <= 1'b0;
    end else if (wr_ok) begin
      if (idx == REG_PAGE) begin
        page_r <= WRITEDATA[15:0];
      end
      if (page_r == PAGE_MAIN && idx == REG_CTRL) begin
        near_r <= WRITEDATA[CTRL_NEAR_LB];
        iso_r <= WRITEDATA[CTRL_ISOLATE];
      end
      if (page_r == PAGE_MAIN && idx == REG_EXTCTL1) begin
        far_r <= WRITEDATA[EXT1_FAR_LB];
      end
      if (page_r == PAGE_EXT1 && idx == REG_GEN_CTL) begin
        gen_r <= WRITEDATA[GEN_ENA];
      end
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence wr_at(logic [15:0] p, logic [4:0] i);
    wr_ok && page_r == p && idx == i;
  endsequence
  sequence srst_wr;
    wr_ok && page_r == PAGE_MAIN && idx == REG_CTRL && WRITEDATA[CTRL_SRST] && !SLEEP_HOLD_PIN;
  endsequence
  AST_ACK_ONE: assert property ($rose(READ || WRITE) && PHY_ACTIVE |->
    WAITREQUEST ##1 !WAITREQUEST) else $error("ack not after one wait state");
  AST_WAIT_BOUND: assert property ((READ || WRITE) |-> ##[0:40] !WAITREQUEST)
    else $error("request never answered");
  AST_SLEEP: assert property (SLEEP_HOLD_PIN [*2] |->
    !PHY_ACTIVE && MED_TX == '0 && MAC_RX == '0) else $error("active while sleep held");
  AST_NEAR: assert property ((near_r && !iso_r && !gen_r && PHY_ACTIVE) ##1 PHY_ACTIVE |->
    MAC_RX == $past(MAC_TX) && MED_TX == '0) else $error("near loopback path wrong");
  AST_FAR: assert property ((far_r && !near_r && !gen_r && PHY_ACTIVE) ##1 PHY_ACTIVE |->
    MED_TX == $past(MED_RX)) else $error("far loopback echo wrong");
  AST_ISO: assert property ((iso_r && PHY_ACTIVE) ##1 PHY_ACTIVE |-> MAC_RX == '0)
    else $error("receive outputs live while isolated");
  AST_GEN_RX: assert property ((gen_r && !iso_r && !near_r && PHY_ACTIVE) ##1 PHY_ACTIVE |->
    MAC_RX == $past(MED_RX)) else $error("receive path dead during generator");
  AST_MODE: assert property (wr_at(PAGE_MAIN, REG_EXTCTL1) |->
    ##2 MAC_MODE == $past(WRITEDATA[12:11], 2)) else $error("interface mode not applied");
  AST_RGMII: assert property (wr_at(PAGE_EXT2, REG_RGMII) |-> ##2
    {RGMII_RX_DLY, RGMII_TX_DLY} == {$past(WRITEDATA[6:4], 2), $past(WRITEDATA[2:0], 2)})
    else $error("clock delays not applied");
  AST_SRST: assert property (srst_wr |=> !PHY_ACTIVE [*8] ##[1:40] PHY_ACTIVE)
    else $error("soft reset hold wrong");
endmodule
bind ptb_top ptb_props u_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
  .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST),
  .SLEEP_HOLD_PIN(SLEEP_HOLD_PIN), .MAC_TX(MAC_TX), .MAC_RX(MAC_RX), .MED_RX(MED_RX),
  .MED_TX(MED_TX), .MAC_MODE(MAC_MODE), .RGMII_RX_DLY(RGMII_RX_DLY),
  .RGMII_TX_DLY(RGMII_TX_DLY), .PHY_ACTIVE(PHY_ACTIVE));

//--- tb/ptb_mac_model.sv
// MAC transmit and link partner byte sources for the core.
// Assumes the core samples both streams on the rising edge.
`timescale 1ns/10ps
module ptb_mac_model (
  input wire logic clk,
  input wire logic rst_n,
  output ptb_pkg::ptb_byte_s mac_tx,
  output ptb_pkg::ptb_byte_s med_rx
);
  import ptb_pkg::*;
  logic [7:0] cnt_r;
  // New byte every cycle, so a stale path shows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign mac_tx = '{en: cnt_r[2:0] != 3'h0, d: cnt_r ^ 8'h3C};
  assign med_rx = '{en: cnt_r[1:0] != 2'h3, d: ~cnt_r};
endmodule

//--- tb/ptb_tb_top.sv
// Self-checking bench for the PHY test and bring-up core.
// Assumes the partner model feeds MAC and media bytes every cycle.
`timescale 1ns/10ps
module ptb_tb_top;
  import ptb_pkg::*;
  typedef struct packed {
    logic [4:0] idx;
    logic [15:0] val;
    logic [15:0] rest;
    logic [1:0] txs;
    logic [1:0] rxs;
  } ptb_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] addr = 7'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic sleep = 1'b0;
  logic link = 1'b1;
  logic [15:0] adv, gbc;
  logic [31:0] rdata;
  logic wreq;
  ptb_byte_s mac_tx, mac_rx, med_rx, med_tx;
  logic [1:0] mode, fspd;
  logic [2:0] rxd, txd;
  logic an_en, fdx, conn, swap, dly_on, act;
  int err_total = 0;
  int n_compared = 0;
  // Mode rows: register, value, restore, media source, MAC source
  ptb_row_s rows [4] = '{'{5'h00, 16'h1040, 16'h1040, 2'h1, 2'h2},
    '{5'h00, 16'h5040, 16'h1040, 2'h0, 2'h1}, '{5'h17, 16'h0008, 16'h0000, 2'h2, 2'h2},
    '{5'h00, 16'h1440, 16'h1040, 2'h0, 2'h0}};
  logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h1};
  logic [15:0] pages [4] = '{PAGE_EXT1, PAGE_EXT2, PAGE_GPIO, 16'h0003};
  always #20 clk = ~clk;
  ptb_mac_model u_mac (.clk(clk), .rst_n(rst_n), .mac_tx(mac_tx), .med_rx(med_rx));
  // Identification values are arbitrary
  ptb_top #(.GEN_FRAMES(3), .PHY_ID1(16'h0C0D), .PHY_ID2(16'h0E0F)) DUT (.SYS_CLK(clk),
    .RST_N(rst_n), .ADDRESS(addr), .READ(read), .WRITE(write), .WRITEDATA(wdata),
    .BYTEENABLE(4'hF), .READDATA(rdata), .WAITREQUEST(wreq), .SLEEP_HOLD_PIN(sleep),
    .MAC_TX(mac_tx), .MAC_RX(mac_rx), .MED_RX(med_rx), .MED_RX_ER(1'b0), .MED_LINK(link),
    .MED_TX(med_tx), .MAC_MODE(mode), .AN_ENABLE(an_en), .FORCED_SPEED(fspd),
    .FULL_DUPLEX(fdx), .AN_ADVERT(adv), .GB_CONTROL(gbc), .CONN_LOOPBACK(conn),
    .PAIR_SWAP_OFF(swap), .RGMII_DLY_ON(dly_on), .RGMII_RX_DLY(rxd), .RGMII_TX_DLY(txd),
    .PHY_ACTIVE(act));
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] i, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    @(posedge clk);
    addr <= {i, 2'b00};
    wdata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_total++;
      print_verdict();
    end
    q = rdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [4:0] i, output logic [15:0] q);
    bus(1'b0, i, 16'h0000, q);
  endtask
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, i, 16'h0000, q);
    chk({16'h0000, q}, {16'h0000, e});
  endtask
  function automatic ptb_byte_s pick(input logic [1:0] s, input ptb_byte_s a, ptb_byte_s b);
    return (s == 2'h1) ? a : ((s == 2'h2) ? b : '0);
  endfunction
  initial begin
    logic [15:0] q;
    ptb_byte_s ptx, prx;
    logic pe;
    int n;
    // Two rising edges on reset release
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    // One test mode at a time
    foreach (rows[r]) begin
      wr(rows[r].idx, rows[r].val);
      @(negedge clk);
      ptx = mac_tx;
      prx = med_rx;
      repeat (3) begin
        @(negedge clk);
        chk({23'h0, med_tx}, {23'h0, pick(rows[r].txs, ptx, prx)});
        chk({23'h0, mac_rx}, {23'h0, pick(rows[r].rxs, ptx, prx)});
        ptx = mac_tx;
        prx = med_rx;
      end
      wr(rows[r].idx, rows[r].rest);
    end
    rd_chk(REG_CTRL, CTRL_RST);
    rd_chk(REG_ANADV, ANADV_RST);
    wr(REG_ID1, 16'hFFFF);
    rd_chk(REG_ID1, 16'h0C0D);
    // Mode field by read-modify-write
    foreach (modes[m]) begin
      rd(REG_EXTCTL1, q);
      q[12:11] = modes[m];
      wr(REG_EXTCTL1, q);
      repeat (2) @(negedge clk);
      chk({30'h0, mode}, {30'h0, modes[m]});
    end
    foreach (pages[p]) begin
      wr(REG_PAGE, pages[p]);
      wr(5'h15, 16'h0A00 | pages[p]);
      rd_chk(5'h15, (pages[p] == 16'h0003) ? 16'h0000 : (16'h0A00 | pages[p]));
      rd_chk(REG_EXTCTL1, 16'h0000);
    end
    wr(REG_PAGE, PAGE_MAIN);
    rd_chk(REG_EXTCTL1, 16'h0800);
    wr(REG_MMD_CTL, 16'h0000);
    wr(REG_MMD_DAT, 16'h0003);
    wr(REG_MMD_CTL, 16'h4000);
    wr(REG_MMD_DAT, 16'hBEEF);
    rd_chk(REG_MMD_DAT, 16'hBEEF);
    wr(REG_CTRL, 16'h2100);
    wr(REG_EXTCTL2, 16'h0001);
    wr(REG_BYPASS, 16'h0020);
    wr(REG_GBCTL, 16'h0200);
    repeat (2) @(negedge clk);
    chk({26'h0, an_en, fspd, fdx, conn, swap}, 32'h0000000F);
    chk({adv, gbc}, {ANADV_RST, 16'h0200});
    wr(REG_PAGE, PAGE_EXT2);
    wr(REG_RGMII, 16'h0053);
    repeat (2) @(negedge clk);
    chk({25'h0, dly_on, rxd, txd}, 32'h0000006B);
    wr(REG_PAGE, PAGE_MAIN);
    wr(REG_ANADV, 16'h0000);
    rd(REG_CTRL, q);
    wr(REG_CTRL, q | 16'h8000);
    repeat (SRST_CYC) @(posedge clk);
    n = 0;
    do begin
      rd(REG_CTRL, q);
      n++;
    end while (q[15] !== 1'b0 && n < 50);
    if (q[15] !== 1'b0) begin
      err_total++;
      print_verdict();
    end
    chk({16'h0, q}, {16'h0, CTRL_RST});
    rd_chk(REG_ANADV, ANADV_RST);
    rd_chk(REG_EXTCTL1, 16'h0800);
    wr(REG_PAGE, PAGE_EXT1);
    wr(REG_GEN_CFG, 16'hAB5C);
    wr(REG_GEN_CTL, 16'hC011);
    @(negedge clk);
    pe = 1'b1;
    n = 0;
    while (!(med_tx.en === 1'b1 && pe === 1'b0) && n < 200) begin
      pe = med_tx.en;
      @(negedge clk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      print_verdict();
    end
    for (int b = 0; b < 14; b++) begin
      chk({23'h0, med_tx}, {24'h1, (b < 6) ? 8'hAB : ((b < 12) ? 8'h02 : 8'h5C)});
      @(negedge clk);
    end
    chk({31'h0, med_tx.en}, 32'h0);
    n = 0;
    do begin
      rd(REG_GEN_CTL, q);
      n++;
    end while (q[14] !== 1'b0 && n < 40);
    if (q[14] !== 1'b0) begin
      err_total++;
      print_verdict();
    end
    chk({16'h0, q}, 32'h00008011);
    wr(REG_GEN_CTL, 16'h0000);
    wr(REG_PAGE, PAGE_MAIN);
    rd_chk(REG_IRQ_STAT, 16'h0001);
    rd_chk(REG_IRQ_STAT, 16'h0000);
    // Short link drop, latched low until read
    @(posedge clk);
    link <= 1'b0;
    @(posedge clk);
    link <= 1'b1;
    rd_chk(REG_STAT, STAT_RST);
    rd_chk(REG_STAT, 16'h7004);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(negedge clk);
    chk({13'h0, act, med_tx, mac_rx}, 32'h0);
    @(posedge clk);
    sleep <= 1'b0;
    repeat (2) @(negedge clk);
    chk({31'h0, act}, 32'h1);
    print_verdict();
  end
endmodule
